// ===== flash_host_pkg.sv
// constants for the dual-die parallel flash host controller
package flash_host_pkg;
  localparam int addr_w = 22;
  localparam int data_w = 16;
  localparam int sector_bit = 15;
  localparam logic [addr_w-1:0] unlock_addr_a = 22'h000555;
  localparam logic [addr_w-1:0] unlock_addr_b = 22'h0002aa;
  localparam logic [data_w-1:0] unlock_data_a = 16'h00aa;
  localparam logic [data_w-1:0] unlock_data_b = 16'h0055;
  localparam logic [data_w-1:0] cmd_program = 16'h00a0;
  localparam logic [data_w-1:0] cmd_erase_setup = 16'h0080;
  localparam logic [data_w-1:0] cmd_chip_erase = 16'h0010;
  localparam logic [data_w-1:0] cmd_sector_erase = 16'h0030;
  localparam logic [data_w-1:0] cmd_bypass_enter = 16'h0020;
  localparam logic [data_w-1:0] cmd_bypass_exit_a = 16'h0090;
  localparam logic [data_w-1:0] cmd_bypass_exit_b = 16'h0000;
  localparam logic [data_w-1:0] cmd_suspend = 16'h00b0;
  localparam logic [data_w-1:0] cmd_resume = 16'h0030;
  localparam logic [data_w-1:0] cmd_reset = 16'h00f0;
  localparam int data_poll_bit = 7;
  localparam int toggle_bit = 6;
  localparam int clk_period_ns = 100;
  localparam int write_pulse_ns = 200;
  localparam int write_pulse_cyc =
    (write_pulse_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int read_access_ns = 200;
  localparam int read_access_cyc =
    (read_access_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int reset_pulse_ns = 500;
  localparam int reset_pulse_cyc =
    (reset_pulse_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [2:0] op_read = 3'h0;
  localparam logic [2:0] op_program = 3'h1;
  localparam logic [2:0] op_sector_erase = 3'h2;
  localparam logic [2:0] op_chip_erase = 3'h3;
  localparam logic [2:0] op_suspend = 3'h4;
  localparam logic [2:0] op_resume = 3'h5;
  localparam logic [2:0] op_bypass_enter = 3'h6;
  localparam logic [2:0] op_bypass_exit = 3'h7;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_setup = 3'b001,
    st_pulse = 3'b011,
    st_gap = 3'b010,
    st_poll = 3'b110,
    st_done = 3'b111,
    st_reset = 3'b101
  } state_e;
endpackage

// ===== flash_host_ctrl.sv
// host controller driving a dual-die parallel flash through its pins
`timescale 1ns/10ps
module flash_host_ctrl
  import flash_host_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic req_die,
  input wire logic [addr_w-1:0] req_addr,
  input wire logic [data_w-1:0] req_wdata,
  input wire logic req_accel,
  input wire logic req_hw_reset,
  output logic req_ready,
  output logic done_pulse,
  output logic fail_pulse,
  output logic [data_w-1:0] rdata,
  output logic bypass_active,
  output logic first_die_select_n,
  output logic second_die_select_n,
  output logic write_enable_n,
  output logic output_enable_n,
  output logic flash_reset_n,
  output logic program_accelerate,
  output logic [addr_w-1:0] flash_addr,
  output logic [data_w-1:0] word_data_bus_out,
  output logic word_data_bus_oe,
  input wire logic [data_w-1:0] word_data_bus_in,
  input wire logic ready_busy_n
);
  logic rst_meta_r;
  logic rst_sync_r;
  state_e state_r;
  logic [2:0] op_r;
  logic die_r;
  logic [addr_w-1:0] addr_r;
  logic [data_w-1:0] wdata_r;
  logic [2:0] step_r;
  logic [2:0] nsteps_r;
  logic [3:0] cnt_r;
  logic poll_rd_r;
  logic have_prev_r;
  logic [data_w-1:0] prev_r;
  logic bypass_r;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // number of bus writes in each command sequence
  function automatic logic [2:0] seq_len(input logic [2:0] op, input logic byp);
    case (op)
      op_program: seq_len = byp ? 3'h2 : 3'h4;
      op_sector_erase: seq_len = 3'h6;
      op_chip_erase: seq_len = 3'h6;
      op_bypass_enter: seq_len = 3'h3;
      op_bypass_exit: seq_len = 3'h2;
      op_suspend: seq_len = 3'h1;
      op_resume: seq_len = 3'h1;
      default: seq_len = 3'h1;
    endcase
  endfunction

  // address and data of write number step
  function automatic logic [addr_w+data_w-1:0] seq_word(input logic [2:0] op,
    input logic [2:0] step, input logic byp, input logic [addr_w-1:0] a,
    input logic [data_w-1:0] d);
    logic [addr_w-1:0] sa;
    sa = {a[addr_w-1:sector_bit], {sector_bit{1'b0}}};
    seq_word = {unlock_addr_a, cmd_reset};
    case (op)
      op_program:
        if (byp)
          seq_word = (step == 3'h0) ? {unlock_addr_a, cmd_program} : {a, d};
        else
          case (step)
            3'h0: seq_word = {unlock_addr_a, unlock_data_a};
            3'h1: seq_word = {unlock_addr_b, unlock_data_b};
            3'h2: seq_word = {unlock_addr_a, cmd_program};
            default: seq_word = {a, d};
          endcase
      op_sector_erase, op_chip_erase:
        case (step)
          3'h0, 3'h3: seq_word = {unlock_addr_a, unlock_data_a};
          3'h1, 3'h4: seq_word = {unlock_addr_b, unlock_data_b};
          3'h2: seq_word = {unlock_addr_a, cmd_erase_setup};
          default: seq_word = (op == op_chip_erase) ? {unlock_addr_a, cmd_chip_erase}
                                                   : {sa, cmd_sector_erase};
        endcase
      op_bypass_enter:
        case (step)
          3'h0: seq_word = {unlock_addr_a, unlock_data_a};
          3'h1: seq_word = {unlock_addr_b, unlock_data_b};
          default: seq_word = {unlock_addr_a, cmd_bypass_enter};
        endcase
      op_bypass_exit:
        seq_word = (step == 3'h0) ? {unlock_addr_a, cmd_bypass_exit_a}
                                  : {unlock_addr_a, cmd_bypass_exit_b};
      op_suspend: seq_word = {a, cmd_suspend};
      op_resume: seq_word = {a, cmd_resume};
      default: seq_word = {unlock_addr_a, cmd_reset};
    endcase
  endfunction

  logic [addr_w+data_w-1:0] cur_word;
  logic polls;
  // accelerate level shortens program to the bypass form as well
  assign cur_word = seq_word(op_r, step_r, bypass_r || program_accelerate,
                             addr_r, wdata_r);
  assign polls = (op_r == op_program) || (op_r == op_sector_erase) ||
                 (op_r == op_chip_erase);
  assign req_ready = (state_r == st_idle);
  assign bypass_active = bypass_r;

  // sequencer
  always_ff @(posedge ref_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      state_r <= st_reset;
      op_r <= op_read;
      die_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      step_r <= 3'h0;
      nsteps_r <= 3'h1;
      cnt_r <= 4'h0;
      poll_rd_r <= 1'b0;
      have_prev_r <= 1'b0;
      prev_r <= '0;
      rdata <= '0;
      done_pulse <= 1'b0;
      fail_pulse <= 1'b0;
    end
    else
    begin
      done_pulse <= 1'b0;
      fail_pulse <= 1'b0;
      case (state_r)
        st_idle:
          if (req_hw_reset)
          begin
            state_r <= st_reset;
            cnt_r <= 4'h0;
          end
          else if (req_valid)
          begin
            op_r <= req_op;
            die_r <= req_die;
            addr_r <= req_addr;
            wdata_r <= req_wdata;
            step_r <= 3'h0;
            nsteps_r <= seq_len(req_op, bypass_r || req_accel);
            cnt_r <= 4'h0;
            state_r <= st_setup;
          end
        st_setup:
          state_r <= (op_r == op_read) ? st_poll : st_pulse;
        st_pulse:
          if (cnt_r == 4'(write_pulse_cyc - 1))
          begin
            cnt_r <= 4'h0;
            state_r <= st_gap;
          end
          else
            cnt_r <= cnt_r + 4'h1;
        st_gap:
          if (step_r == nsteps_r - 3'h1)
          begin
            state_r <= polls ? st_poll : st_done;
            have_prev_r <= 1'b0;
            poll_rd_r <= 1'b0;
            cnt_r <= 4'h0;
          end
          else
          begin
            step_r <= step_r + 3'h1;
            state_r <= st_pulse;
          end
        st_poll:
          if (cnt_r == 4'(read_access_cyc))
          begin
            cnt_r <= 4'h0;
            rdata <= word_data_bus_in;
            if (op_r == op_read)
              state_r <= st_done;
            else if (have_prev_r &&
                     (prev_r[toggle_bit] == word_data_bus_in[toggle_bit]) &&
                     ready_busy_n)
              state_r <= st_done;
            prev_r <= word_data_bus_in;
            have_prev_r <= 1'b1;
            poll_rd_r <= 1'b1;
          end
          else
            cnt_r <= cnt_r + 4'h1;
        st_done:
        begin
          // last polled word must carry the written polling bit
          fail_pulse <= (op_r == op_program) &&
                        (rdata[data_poll_bit] != wdata_r[data_poll_bit]);
          done_pulse <= 1'b1;
          state_r <= st_idle;
        end
        st_reset:
          if (cnt_r == 4'(reset_pulse_cyc - 1))
          begin
            cnt_r <= 4'h0;
            state_r <= st_idle;
          end
          else
            cnt_r <= cnt_r + 4'h1;
        default: state_r <= st_idle;
      endcase
    end
  end

  // bypass mode tracking
  always_ff @(posedge ref_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      bypass_r <= 1'b0;
    else if (state_r == st_reset)
      bypass_r <= 1'b0;
    else if (state_r == st_done && op_r == op_bypass_enter)
      bypass_r <= 1'b1;
    else if (state_r == st_done && op_r == op_bypass_exit)
      bypass_r <= 1'b0;
  end

  // pin drivers
  always_ff @(posedge ref_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      first_die_select_n <= 1'b1;
      second_die_select_n <= 1'b1;
      write_enable_n <= 1'b1;
      output_enable_n <= 1'b1;
      flash_reset_n <= 1'b0;
      program_accelerate <= 1'b0;
      flash_addr <= '0;
      word_data_bus_out <= '0;
      word_data_bus_oe <= 1'b0;
    end
    else
    begin
      flash_reset_n <= (state_r != st_reset);
      if (state_r == st_idle && req_valid)
        program_accelerate <= req_accel;
      first_die_select_n <= !((state_r == st_pulse || state_r == st_poll) && !die_r);
      second_die_select_n <= !((state_r == st_pulse || state_r == st_poll) && die_r);
      write_enable_n <= !(state_r == st_pulse);
      // read strobe rises between polls so the toggle bit can move
      output_enable_n <= !(state_r == st_poll && cnt_r != 4'h0);
      word_data_bus_oe <= (state_r == st_pulse || state_r == st_gap);
      if (state_r == st_pulse || state_r == st_gap || state_r == st_setup)
      begin
        flash_addr <= cur_word[addr_w+data_w-1:data_w];
        word_data_bus_out <= cur_word[data_w-1:0];
      end
      else if (state_r == st_poll)
        flash_addr <= addr_r;
    end
  end
endmodule

// ===== flash_host_sva.sv
// assertions on the flash host controller ports
`timescale 1ns/10ps
module flash_host_sva
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic done_pulse,
  input wire logic fail_pulse,
  input wire logic req_ready,
  input wire logic first_die_select_n,
  input wire logic second_die_select_n,
  input wire logic write_enable_n,
  input wire logic output_enable_n,
  input wire logic flash_reset_n,
  input wire logic word_data_bus_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence we_pulse;
    !write_enable_n [*2] ##1 write_enable_n;
  endsequence
  a_one_die: assert property (first_die_select_n || second_die_select_n)
    else $error("both die selects low");
  a_we_oe_excl: assert property (write_enable_n || output_enable_n)
    else $error("write and read strobes together");
  a_we_drives: assert property (!write_enable_n |-> word_data_bus_oe)
    else $error("write without data drive");
  a_we_width: assert property ($fell(write_enable_n) |-> we_pulse)
    else $error("write pulse width wrong");
  a_no_fight: assert property (!output_enable_n |-> !word_data_bus_oe)
    else $error("bus driven during read");
  a_done_once: assert property (done_pulse |=> !done_pulse)
    else $error("done longer than one cycle");
  a_fail_done: assert property (fail_pulse |-> done_pulse)
    else $error("fail without done");
  a_ready_after: assert property (done_pulse |-> ##[0:2] req_ready)
    else $error("not ready after done");
  a_reset_len: assert property ($fell(flash_reset_n) |-> !flash_reset_n [*5])
    else $error("flash reset pulse too short");
endmodule

// ===== flash_die_model.sv
// behavioural model of one flash die on the shared bus
`timescale 1ns/10ps
module flash_die_model
  import flash_host_pkg::*;
#(parameter int busy_cyc = 30, parameter int prot_sect = -1)
(
  input wire logic ref_clk,
  input wire logic sel_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic rst_n,
  input wire logic acc,
  input wire logic temp_unprot,
  input wire logic low_supply,
  input wire logic [addr_w-1:0] addr,
  input wire logic [data_w-1:0] din,
  output logic [data_w-1:0] dout,
  output logic dout_oe,
  output logic rb_n
);
  logic [data_w-1:0] mem [int];
  logic [79:0] hist = '0;
  logic [31:0] unl;
  logic [data_w-1:0] pd = '0;
  logic byp = 0, prg = 0, we_q = 1, oe_q = 1, tog = 0;
  int busy = 0;
  function automatic logic [data_w-1:0] rd(input int a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction
  assign unl = {unlock_data_a, unlock_data_b};
  assign rb_n = (busy == 0);
  assign dout_oe = !sel_n && !oe_n;
  assign dout = busy ? {~pd[7], tog, 14'h0} : rd(int'(addr));
  always @(posedge ref_clk)
  begin
    we_q <= we_n;
    oe_q <= oe_n;
    if (!rst_n)
    begin
      busy <= 0;
      byp <= 0;
      prg <= 0;
      hist <= '0;
    end
    else
    begin
      if (busy > 0) busy <= busy - 1;
      if (busy > 0 && oe_q && !oe_n && !sel_n) tog <= !tog;
      if (!sel_n && we_q && !we_n && busy == 0 && !low_supply)
      begin
        hist <= {hist[63:0], din};
        if (prg)
        begin
          if (temp_unprot || int'(addr[21:15]) != prot_sect)
            mem[int'(addr)] = rd(int'(addr)) & din;
          pd <= din;
          prg <= 0;
          busy <= busy_cyc;
        end
        else if (din == cmd_program && (byp || acc || hist[31:0] == unl)) prg <= 1;
        else if (hist[31:0] == unl && din == cmd_bypass_enter) byp <= 1;
        else if (byp && hist[15:0] == cmd_bypass_exit_a && din == cmd_bypass_exit_b) byp <= 0;
        else if (hist == {unl, cmd_erase_setup, unl})
        begin
          foreach (mem[k])
            if ((din == cmd_chip_erase || k[21:15] == addr[21:15]) &&
                (temp_unprot || int'(k[21:15]) != prot_sect))
              mem[k] = 16'hffff;
          pd <= 16'hffff;
          busy <= busy_cyc;
        end
      end
    end
  end
endmodule

// ===== tb.sv
// testbench for the flash host controller against two die models
`timescale 1ns/10ps
module tb
  import flash_host_pkg::*;
  ;
  logic ref_clk = 0, reset_n = 0, req_valid = 0, req_die = 0, req_accel = 0, req_hw_reset = 0;
  logic [2:0] req_op = '0;
  logic [addr_w-1:0] req_addr = '0, flash_addr;
  logic [data_w-1:0] req_wdata = '0, rdata, word_data_bus_out, d0, d1, dq, last_bus = '0;
  logic req_ready, done_pulse, fail_pulse, bypass_active, first_die_select_n;
  logic second_die_select_n, write_enable_n, output_enable_n, flash_reset_n;
  logic program_accelerate, word_data_bus_oe, oe0, oe1, rb0, rb1, got_fail;
  logic unprot = 0, low_supply = 0;
  logic [data_w-1:0] last_wr = '0;
  int n_fail = 0, checked = 0;
  assign dq = word_data_bus_oe ? word_data_bus_out : oe0 ? d0 : oe1 ? d1 : ~last_bus;
  flash_host_ctrl uut (.ref_clk, .reset_n, .req_valid, .req_op, .req_die, .req_addr,
    .req_wdata, .req_accel, .req_hw_reset, .req_ready, .done_pulse, .fail_pulse, .rdata,
    .bypass_active, .first_die_select_n, .second_die_select_n, .write_enable_n,
    .output_enable_n, .flash_reset_n, .program_accelerate, .flash_addr, .word_data_bus_out,
    .word_data_bus_oe, .word_data_bus_in(dq), .ready_busy_n(rb0 & rb1));
  flash_die_model #(.prot_sect(2)) m0 (.ref_clk, .sel_n(first_die_select_n),
    .we_n(write_enable_n), .temp_unprot(unprot), .low_supply,
    .oe_n(output_enable_n), .rst_n(flash_reset_n), .acc(program_accelerate),
    .addr(flash_addr), .din(dq), .dout(d0), .dout_oe(oe0), .rb_n(rb0));
  flash_die_model m1 (.ref_clk, .sel_n(second_die_select_n), .we_n(write_enable_n),
    .temp_unprot(unprot), .low_supply,
    .oe_n(output_enable_n), .rst_n(flash_reset_n), .acc(program_accelerate),
    .addr(flash_addr), .din(dq), .dout(d1), .dout_oe(oe1), .rb_n(rb1));
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) last_bus <= dq;
  always @(posedge ref_clk) if (!write_enable_n) last_wr <= dq;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic req(input logic [2:0] op, input logic die, input logic [21:0] a,
    input logic [15:0] d, input logic acc);
    int n;
    n = 0;
    req_op = op;
    req_die = die;
    req_addr = a;
    req_wdata = d;
    req_accel = acc;
    req_valid = 1;
    while (!req_ready && n < 50)
    begin
      @(posedge ref_clk) #1;
      n++;
    end
    @(posedge ref_clk) #1;
    req_valid = 0;
    n = 0;
    while (!done_pulse && n < 5000)
    begin
      @(posedge ref_clk) #1;
      n++;
    end
    got_fail = fail_pulse;
    chk(done_pulse, 1);
  endtask
  task automatic t_prog;
    req(op_program, 0, 22'h008010, 16'h1234, 0);
    chk(got_fail, 0);
    req(op_read, 0, 22'h008010, 0, 0);
    chk(rdata, 16'h1234);
    req(op_program, 0, 22'h008010, 16'h00ff, 0);
    chk(got_fail, 1);
    req(op_read, 1, 22'h008010, 0, 0);
    chk(rdata, 16'hffff);
    $display("t_prog done");
  endtask
  task automatic t_bypass;
    req(op_bypass_enter, 1, 0, 0, 0);
    chk(bypass_active, 1);
    req(op_program, 1, 22'h3f0001, 16'habcd, 0);
    req(op_read, 1, 22'h3f0001, 0, 0);
    chk(rdata, 16'habcd);
    req(op_bypass_exit, 1, 0, 0, 0);
    chk(bypass_active, 0);
    req(op_program, 0, 22'h000100, 16'h5a5a, 1);
    req(op_read, 0, 22'h000100, 0, 0);
    chk(rdata, 16'h5a5a);
    $display("t_bypass done");
  endtask
  task automatic t_erase;
    req(op_sector_erase, 0, 22'h008000, 0, 0);
    req(op_read, 0, 22'h008010, 0, 0);
    chk(rdata, 16'hffff);
    req(op_read, 0, 22'h000100, 0, 0);
    chk(rdata, 16'h5a5a);
    req(op_chip_erase, 1, 0, 0, 0);
    req(op_read, 1, 22'h3f0001, 0, 0);
    chk(rdata, 16'hffff);
    $display("t_erase done");
  endtask
  task automatic t_reset;
    int n;
    n = 0;
    req_hw_reset = 1;
    @(posedge ref_clk) #1;
    req_hw_reset = 0;
    while (flash_reset_n && n < 20)
    begin
      @(posedge ref_clk) #1;
      n++;
    end
    chk(flash_reset_n, 0);
    req(op_read, 0, 22'h000100, 0, 0);
    chk(rdata, 16'h5a5a);
    $display("t_reset done");
  endtask
  task automatic t_protect;
    req(op_program, 0, 22'h010004, 16'h0f0f, 0);
    chk(got_fail, 1);
    unprot = 1;
    req(op_program, 0, 22'h010004, 16'h0f0f, 0);
    chk(got_fail, 0);
    unprot = 0;
    req(op_sector_erase, 0, 22'h010000, 0, 0);
    req(op_read, 0, 22'h010004, 0, 0);
    chk(rdata, 16'h0f0f);
    low_supply = 1;
    req(op_program, 0, 22'h000200, 16'h0000, 0);
    chk(got_fail, 1);
    low_supply = 0;
    req(op_read, 0, 22'h000200, 0, 0);
    chk(rdata, 16'hffff);
    $display("t_protect done");
  endtask
  task automatic t_suspend;
    req(op_suspend, 0, 22'h008000, 0, 0);
    chk(last_wr, cmd_suspend);
    req(op_resume, 0, 22'h008000, 0, 0);
    chk(last_wr, cmd_resume);
    $display("t_suspend done");
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    #1 reset_n = 1;
    repeat (10) @(posedge ref_clk);
    #1;
    t_prog();
    t_bypass();
    t_erase();
    t_reset();
    t_protect();
    t_suspend();
    end_sim();
  end
  initial
  begin
    #3000000;
    n_fail++;
    end_sim();
  end
endmodule
bind flash_host_ctrl flash_host_sva chk_i (.ref_clk, .reset_n, .done_pulse, .fail_pulse,
  .req_ready, .first_die_select_n, .second_die_select_n, .write_enable_n, .output_enable_n,
  .flash_reset_n, .word_data_bus_oe);
